// ==== logic/scclp_top.sv ====
// Clock control register, low-power sequencer and clock gating for the system clock module.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - IRQ pins wake only when wake mask set.
// - Timebase source: oscillator/4 or system clock/4.
// - Decrementer clock gate bit, set after reset.
// - Lock loss requests reset only when enabled.
// - Bypass reports unlock; software keeps enable clear.
// - Oscillator loss requests reset only when enabled.
// - Multiply low three bits give x4..x11.
// - Low-power field: normal, single, doze, sleep.
// - Sleep exit waits oscillator start and lock.
// - Divide by two power code, capped 1024.
// - Clock mode decides which fields apply.
// - Exit event returns low-power field to normal.
// - Block bus, finish cycle, then stop clocks.
// - Lock bits block writes to their fields.
module scclp_top
  import scclp_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = XTAL_STARTUP_CYC + PLL_LOCK_CYC
) (
  input  wire logic                      clk,              // System clock, 25 MHz.
  input  wire logic                      reset,            // Asynchronous reset, active high.
  input  wire scclp_pkg::scclp_bus_req_t bus_req,          // Register port request.
  output logic [31:0]                    bus_rdata,        // Read data, cycle after the read.
  input  wire logic                      osc_tick,         // One-cycle pulse per oscillator edge.
  input  wire logic                      pll_locked,       // PLL lock detector level.
  input  wire logic                      osc_present,      // Oscillator detector level.
  input  wire logic [1:0]                clock_mode,       // Strap: 3 normal, 2 one-to-one, 1 bypass.
  input  wire scclp_pkg::scclp_wake_t    wake_in,          // Low-power exit event levels.
  input  wire logic                      bus_cycle_busy,   // Processor bus cycle in progress.
  output scclp_pkg::scclp_pll_cfg_t      pll_cfg,          // Feedback and output divide setting.
  output logic                           timebase_tick,    // Time base advance pulse.
  output logic                           decrementer_tick, // Gated decrementer advance pulse.
  output logic                           reset_request,    // Clock-fault reset request level.
  output logic                           bus_block,        // Holds off new bus cycles.
  output logic                           clkout_enable,    // External clock output running.
  output logic                           core_clk_enable,  // Internal clocks running.
  output logic                           osc_pll_enable,   // Oscillator and PLL powered.
  output logic                           irq               // Level interrupt to the processor.
);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Sequencer states: running, draining the bus, stopped, restarting.
  typedef enum logic [1:0] {
    SCCLP_RUN,
    SCCLP_DRAIN,
    SCCLP_LOW,
    SCCLP_WAKE
  } scclp_state_t;

  // Wide enough to hold the full restart count.
  localparam int CW = $clog2(STARTUP_CYCLES + 1);

  // A zero count would leave the restart counter with no bits at all.
  if (STARTUP_CYCLES < 1) begin : g_bad_startup
    $error("STARTUP_CYCLES must be at least one");
  end

  logic [31:0]           ctrl_ff;           // Control word.
  logic [2:0]            lock_ff;           // Field locks: multiply, low-power, divide.
  logic [NUM_EVENTS-1:0] status_ff;         // Sticky event bits.
  logic [NUM_EVENTS-1:0] mask_ff;           // Interrupt enables.
  logic [31:0]           rdata_ff;          // Registered read data.
  scclp_state_t          state_ff;          // Low-power sequencer state.
  logic [CW-1:0]         wait_ff;           // Sleep exit counter.
  logic [1:0]            prescale_ff;       // Divide-by-four counter for the time base.
  logic                  wr_ctrl;           // Write to control word.
  logic                  rd_status;         // Read of status register.
  logic [31:0]           wr_merge;          // Control word after honouring locks.
  scclp_lpm_t            lowpower_mode_select;               // Current low-power selection.
  logic                  wake_event;        // Exit event for the current mode.
  logic                  lol_fault;         // Lock loss with reset enabled.
  logic                  loo_fault;         // Oscillator loss with reset enabled.
  logic [NUM_EVENTS-1:0] events;            // Event pulses into status.
  logic                  tb_source;         // Selected time base source pulse.

  // Decode of the current mode and of the register accesses.
  assign lowpower_mode_select       = scclp_lpm_t'(ctrl_ff[POS_LPM_LSB +: 2]);
  assign wr_ctrl   = bus_req.wr && (bus_req.addr == ADDR_CLOCK_CONTROL);
  assign rd_status = bus_req.rd && (bus_req.addr == ADDR_IRQ_STATUS);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Control word write, with lock masking and hardware return to normal.

  // Locked fields keep their old value whatever the write carries.
  always_comb begin
    wr_merge = (bus_req.wdata & CTRL_WMASK) | (ctrl_ff & ~CTRL_WMASK);
    if (lock_ff[2]) begin
      wr_merge[POS_MF_LSB +: 4] = ctrl_ff[POS_MF_LSB +: 4];
    end
    if (lock_ff[1]) begin
      wr_merge[POS_LPM_LSB +: 2] = ctrl_ff[POS_LPM_LSB +: 2];
    end
    if (lock_ff[0]) begin
      wr_merge[POS_RFD_LSB +: 4] = ctrl_ff[POS_RFD_LSB +: 4];
    end
  end

  // The exit event clears the mode field and wins over a same-cycle write.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wr_merge;
      end
      if (wake_event) begin
        ctrl_ff[POS_LPM_LSB +: 2] <= SCCLP_LPM_NORMAL;
      end
    end
  end

  // Multiply and low-power locks are set-once; the divide lock may be cleared.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_ff <= 3'h0;
    end else if (bus_req.wr && (bus_req.addr == ADDR_FIELD_LOCK)) begin
      lock_ff[2] <= lock_ff[2] | bus_req.wdata[POS_LOCK_MF];
      lock_ff[1] <= lock_ff[1] | bus_req.wdata[POS_LOCK_LPM];
      lock_ff[0] <= bus_req.wdata[POS_LOCK_RFD];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Low-power sequencer.

  // Selects which events end the current mode.
  always_comb begin
    wake_event = 1'b0;
    if (lowpower_mode_select != SCCLP_LPM_NORMAL) begin
      wake_event = wake_in.reset_output;
      if (ctrl_ff[POS_WAKE_MASK] && wake_in.irq_n_asserted) begin
        wake_event = 1'b1;
      end
      if ((lowpower_mode_select != SCCLP_LPM_SLEEP) && (wake_in.decrementer_irq || wake_in.periodic_irq)) begin
        wake_event = 1'b1;
      end
    end
  end

  // Drains the bus before stopping clocks, and times the restart after sleep.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= SCCLP_RUN;
      wait_ff  <= '0;
    end else begin
      case (state_ff)
        SCCLP_RUN: begin
          if (lowpower_mode_select != SCCLP_LPM_NORMAL && !wake_event) begin
            state_ff <= SCCLP_DRAIN;
          end
        end
        SCCLP_DRAIN: begin
          // An exit event, or a field cleared by software, cancels the stop.
          if (wake_event || (lowpower_mode_select == SCCLP_LPM_NORMAL)) begin
            state_ff <= SCCLP_RUN;
          end else if (!bus_cycle_busy) begin
            state_ff <= SCCLP_LOW;
          end
        end
        SCCLP_LOW: begin
          if (wake_event) begin
            // Sleep stopped oscillator and PLL, so wait for both to settle.
            if (lowpower_mode_select == SCCLP_LPM_SLEEP) begin
              state_ff <= SCCLP_WAKE;
              wait_ff  <= CW'(STARTUP_CYCLES);
            end else begin
              state_ff <= SCCLP_RUN;
            end
          end else if (lowpower_mode_select == SCCLP_LPM_NORMAL) begin
            // A field cleared by a write must not strand the sequencer here.
            state_ff <= SCCLP_RUN;
          end
        end
        SCCLP_WAKE: begin
          // Counts down the combined oscillator start-up and lock time.
          if (wait_ff == '0) begin
            state_ff <= SCCLP_RUN;
          end else begin
            wait_ff <= wait_ff - CW'(1);
          end
        end
        default: begin
          // An unused state code falls back to running.
          state_ff <= SCCLP_RUN;
        end
      endcase
    end
  end

  // Clock gating per mode; the mode field already reads normal during wake.
  always_comb begin
    bus_block       = (state_ff != SCCLP_RUN) || (lowpower_mode_select != SCCLP_LPM_NORMAL);
    clkout_enable   = 1'b1;
    core_clk_enable = 1'b1;
    osc_pll_enable  = 1'b1;
    if (state_ff == SCCLP_LOW) begin
      clkout_enable   = 1'b0;
      core_clk_enable = (lowpower_mode_select == SCCLP_LPM_SINGLE);
      osc_pll_enable  = (lowpower_mode_select != SCCLP_LPM_SLEEP);
    end else if (state_ff == SCCLP_WAKE) begin
      clkout_enable   = 1'b0;
      core_clk_enable = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // PLL configuration and fault reset requests.

  // Low three multiply bits plus four; divide as a power of two capped at the ceiling code.
  always_comb begin
    pll_cfg.feedback_mult = {1'b0, ctrl_ff[POS_MF_LSB +: 3]} + {1'b0, MF_BASE};
    pll_cfg.output_divide = 11'h1 << ((ctrl_ff[POS_RFD_LSB +: 4] > RFD_MAX_CODE)
                            ? RFD_MAX_CODE : ctrl_ff[POS_RFD_LSB +: 4]);
    pll_cfg.divide_active = (clock_mode != 2'h2);
  end

  // In bypass the detector reads unlocked, so an enabled lock-loss reset fires.
  assign lol_fault     = ctrl_ff[POS_LOL_RESET] && !pll_locked;
  assign loo_fault     = ctrl_ff[POS_LOO_RESET] && !osc_present;
  assign reset_request = lol_fault || loo_fault;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Time base and decrementer ticks.

  // The system clock source counts every cycle; the oscillator source counts its pulses.
  assign tb_source = ctrl_ff[POS_TB_SOURCE] ? 1'b1 : osc_tick;

  // Counts source pulses and emits one tick every fourth.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prescale_ff <= 2'h0;
    end else if (tb_source && core_clk_enable) begin
      prescale_ff <= prescale_ff + 2'h1;
    end
  end

  // The tick falls on every fourth source pulse; the gate only masks the decrementer copy.
  assign timebase_tick    = tb_source && core_clk_enable && (prescale_ff == 2'(TB_PRESCALE - 1));
  assign decrementer_tick = timebase_tick && ctrl_ff[POS_DEC_GATE];

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.

  // Event pulses: wake, fault requests, and the step into a stopped mode.
  assign events[EV_WAKE]    = wake_event;
  assign events[EV_LOL_RST] = lol_fault;
  assign events[EV_LOO_RST] = loo_fault;
  assign events[EV_SLEPT]   = (state_ff == SCCLP_DRAIN) && !bus_cycle_busy && !wake_event
                              && (lowpower_mode_select != SCCLP_LPM_NORMAL);

  // A read clears status; an event in the same cycle survives.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_ff <= '0;
    end else begin
      status_ff <= (rd_status ? '0 : status_ff) | events;
    end
  end

  // Mask register write.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_ff <= '0;
    end else if (bus_req.wr && (bus_req.addr == ADDR_IRQ_MASK)) begin
      mask_ff <= bus_req.wdata[NUM_EVENTS-1:0];
    end
  end

  // The interrupt stays high while any unmasked sticky bit is set.
  assign irq = |(status_ff & mask_ff);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Register read port; unmapped addresses read zero.

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= 32'h0;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CLOCK_CONTROL: rdata_ff <= ctrl_ff;
        ADDR_FIELD_LOCK:    rdata_ff <= {5'h0, lock_ff, 24'h0};
        ADDR_IRQ_STATUS:    rdata_ff <= {28'h0, status_ff};
        ADDR_IRQ_MASK:      rdata_ff <= {28'h0, mask_ff};
        ADDR_CLOCK_STATUS:  rdata_ff <= {28'h0, state_ff, pll_locked, osc_present};
        default:            rdata_ff <= 32'h0;
      endcase
    end else begin
      rdata_ff <= 32'h0;
    end
  end

  // Read data come straight from the register, so they stand for one cycle only.
  assign bus_rdata = rdata_ff;

endmodule

// ==== common/scclp_pkg.sv ====
// Package for the system clock control and low-power block.
package scclp_pkg;

  // Register map, byte addresses.
  localparam logic [31:0] ADDR_CLOCK_CONTROL = 32'h8007fc50;
  localparam logic [31:0] ADDR_FIELD_LOCK    = 32'h8007fc54;
  localparam logic [31:0] ADDR_IRQ_STATUS    = 32'h8007fc58;
  localparam logic [31:0] ADDR_IRQ_MASK      = 32'h8007fc5c;
  localparam logic [31:0] ADDR_CLOCK_STATUS  = 32'h8007fc60;

  // Field positions, counted from the least significant bit (big-endian bit n is 31-n).
  localparam int POS_WAKE_MASK   = 28;
  localparam int POS_TB_SOURCE   = 27;
  localparam int POS_DEC_GATE    = 26;
  localparam int POS_LOL_RESET   = 25;
  localparam int POS_LOO_RESET   = 24;
  localparam int POS_MF_LSB      = 19;
  localparam int POS_LPM_LSB     = 8;
  localparam int POS_RFD_LSB     = 0;
  localparam int POS_LOCK_MF     = 26;
  localparam int POS_LOCK_LPM    = 25;
  localparam int POS_LOCK_RFD    = 24;

  // Writable bits of the control word, and its reset value.
  localparam logic [31:0] CTRL_WMASK = 32'h1f78030f;
  localparam logic [31:0] CTRL_RESET = 32'h04100003;

  // Interrupt status bit positions.
  localparam int EV_WAKE     = 0;
  localparam int EV_LOL_RST  = 1;
  localparam int EV_LOO_RST  = 2;
  localparam int EV_SLEPT    = 3;
  localparam int NUM_EVENTS  = 4;

  // Divide ceiling for the output divider code, and the multiply offset.
  localparam logic [3:0] RFD_MAX_CODE = 4'ha;
  localparam logic [2:0] MF_BASE      = 3'h4;

  // Clock rate, wake timing and time base prescale.
  localparam int CLK_HZ            = 25000000;
  localparam int XTAL_STARTUP_US   = 10000;
  localparam int PLL_LOCK_US       = 1000;
  localparam int XTAL_STARTUP_CYC  = XTAL_STARTUP_US * (CLK_HZ / 1000000);
  localparam int PLL_LOCK_CYC      = PLL_LOCK_US * (CLK_HZ / 1000000);
  localparam int TB_PRESCALE       = 4;

  // Low-power mode encodings.
  typedef enum logic [1:0] {
    SCCLP_LPM_NORMAL = 2'h0,
    SCCLP_LPM_SINGLE = 2'h1,
    SCCLP_LPM_DOZE   = 2'h2,
    SCCLP_LPM_SLEEP  = 2'h3
  } scclp_lpm_t;

  // Register port request.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } scclp_bus_req_t;

  // Wake and reset event inputs.
  typedef struct packed {
    logic irq_n_asserted;
    logic decrementer_irq;
    logic periodic_irq;
    logic reset_output;
  } scclp_wake_t;

  // PLL configuration that the analog block consumes.
  typedef struct packed {
    logic [3:0]  feedback_mult;
    logic [10:0] output_divide;
    logic        divide_active;
  } scclp_pll_cfg_t;

endpackage

// ==== verification/scclp_checker.sv ====
// Port-level assertions for the clock control block.
`timescale 1ns/1ps
module scclp_checker
  import scclp_pkg::*;
(
  input wire logic                      clk,              // Clock.
  input wire logic                      reset,            // Reset.
  input wire scclp_pkg::scclp_bus_req_t bus_req,          // Request.
  input wire logic [31:0]               bus_rdata,        // Read data.
  input wire logic                      osc_tick,         // Osc pulse.
  input wire logic                      pll_locked,       // Lock level.
  input wire logic                      osc_present,      // Osc level.
  input wire logic [1:0]                clock_mode,       // Strap.
  input wire scclp_pkg::scclp_wake_t    wake_in,          // Wake events.
  input wire logic                      bus_cycle_busy,   // Bus busy.
  input wire scclp_pkg::scclp_pll_cfg_t pll_cfg,          // PLL setting.
  input wire logic                      timebase_tick,    // Base tick.
  input wire logic                      decrementer_tick, // Dec tick.
  input wire logic                      reset_request,    // Fault reset.
  input wire logic                      bus_block,        // Bus hold.
  input wire logic                      clkout_enable,    // Out clock.
  input wire logic                      core_clk_enable,  // Core clock.
  input wire logic                      osc_pll_enable,   // Osc power.
  input wire logic                      irq               // Interrupt.
);
  import scclp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // The oscillator coming back marks the start of a sleep exit.
  sequence s_restart;
    $rose(osc_pll_enable);
  endsequence
  // The last cycle before a stop must be drained.
  sequence s_stopped;
    $fell(clkout_enable);
  endsequence
  a_mult_range: assert property (pll_cfg.feedback_mult inside {[4'h4:4'hb]})
    else $error("multiplier outside x4 to x11");
  a_div_pow2: assert property ($onehot(pll_cfg.output_divide))
    else $error("divider is not a power of two");
  a_one_to_one: assert property (clock_mode == 2'h2 |-> !pll_cfg.divide_active)
    else $error("divider active in one-to-one mode");
  a_normal_div: assert property (clock_mode == 2'h3 |-> pll_cfg.divide_active)
    else $error("divider idle in normal mode");
  a_fault_cause: assert property (reset_request |-> !pll_locked || !osc_present)
    else $error("reset request without a clock fault");
  a_dec_gated: assert property (decrementer_tick |-> timebase_tick)
    else $error("decrementer tick without base tick");
  a_drain_first: assert property (s_stopped |-> $past(bus_block) && !$past(bus_cycle_busy))
    else $error("clock stopped before bus cycle ended");
  a_core_off: assert property (!core_clk_enable |-> !clkout_enable)
    else $error("clock output runs with core stopped");
  a_osc_off: assert property (!osc_pll_enable |-> !core_clk_enable)
    else $error("core runs with oscillator stopped");
  a_restart_wait: assert property (s_restart |-> !core_clk_enable [*8])
    else $error("core restarted before start-up wait");
  a_rdata_quiet: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside read answer cycle");
endmodule

bind scclp_top scclp_checker chk_u (.clk, .reset, .bus_req, .bus_rdata, .osc_tick, .pll_locked,
  .osc_present, .clock_mode, .wake_in, .bus_cycle_busy, .pll_cfg, .timebase_tick,
  .decrementer_tick, .reset_request, .bus_block, .clkout_enable, .core_clk_enable,
  .osc_pll_enable, .irq);

// ==== verification/tb_top.sv ====
// Self-checking bench for the clock control block.
`timescale 1ns/1ps
module tb_top;
  import scclp_pkg::*;
  localparam int SU = 20;                      // Short start-up wait.
  localparam logic [31:0] LPMB = 32'h3 << POS_LPM_LSB;
  localparam logic [31:0] MFRFD = (32'hf << POS_MF_LSB) | 32'hf;
  localparam int REF_MHZ = 4;                  // Reference crystal for the VCO limit check.
  logic           clk = 1'b0;                  // Clock.
  logic           reset = 1'b1;                // Reset.
  scclp_bus_req_t bus_req = '0;                // Register request.
  logic [31:0]    bus_rdata;                   // Read data.
  logic           osc_tick = 1'b0;             // Oscillator pulse.
  logic           pll_locked = 1'b1;           // Lock level.
  logic           osc_present = 1'b1;          // Oscillator level.
  logic [1:0]     clock_mode = 2'h3;           // Strap.
  scclp_wake_t    wake_in = '0;                // Wake events.
  logic           bus_cycle_busy = 1'b0;       // Bus busy.
  scclp_pll_cfg_t pll_cfg;                     // PLL setting.
  logic           timebase_tick, decrementer_tick, reset_request, bus_block;
  logic           clkout_enable, core_clk_enable, osc_pll_enable, irq;
  int             n_fail = 0;                  // Mismatches.
  int             check_count = 0;             // Comparisons.

  // Clock and an oscillator pulse every other cycle.
  always #20 clk = ~clk;
  always @(posedge clk) osc_tick <= ~osc_tick;

  scclp_top #(.STARTUP_CYCLES(SU)) dut_u (.clk, .reset, .bus_req, .bus_rdata, .osc_tick,
    .pll_locked, .osc_present, .clock_mode, .wake_in, .bus_cycle_busy, .pll_cfg,
    .timebase_tick, .decrementer_tick, .reset_request, .bus_block, .clkout_enable,
    .core_clk_enable, .osc_pll_enable, .irq);

  ////////////////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Print counts and the verdict, then stop.
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One-cycle register write, one idle cycle after.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask
  // Read; the data stand only in the next cycle.
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    chk(bus_rdata, exp);
    @(posedge clk);
  endtask
  // Hold the wake level at least three cycles and until the clocks return, at most SU + 8 cycles.
  task automatic hold(output int n);
    n = 0;
    while (n < SU + 8 && (n < 3 || clkout_enable !== 1'b1)) begin
      @(negedge clk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Reset values, writable bits, unmapped space.
  task automatic t_regs;
    rd(ADDR_CLOCK_CONTROL, CTRL_RESET);
    rd(ADDR_FIELD_LOCK, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h0);
    rd(ADDR_CLOCK_STATUS, 32'h3);
    rd(ADDR_CLOCK_CONTROL + 32'h100, 32'h0);
    wr(ADDR_CLOCK_CONTROL, ~LPMB);
    wr(ADDR_CLOCK_CONTROL + 32'h100, 32'h0);
    rd(ADDR_CLOCK_CONTROL, CTRL_WMASK & ~LPMB);
    wr(ADDR_CLOCK_CONTROL, CTRL_RESET);
  endtask
  // Every multiply and divide code, then the one-to-one and bypass clock modes.
  task automatic t_divide;
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_CLOCK_CONTROL, (CTRL_RESET & ~MFRFD) | (32'(c) << POS_MF_LSB) | 32'(c));
      @(negedge clk);
      chk(pll_cfg.feedback_mult, c % 8 + 4);
      chk(pll_cfg.output_divide, 1 << (c > 10 ? 10 : c));
      chk(4 * pll_cfg.feedback_mult * REF_MHZ <= 180, 1'b1);
      @(posedge clk);
    end
    clock_mode <= 2'h2;
    @(negedge clk);
    chk(pll_cfg.divide_active, 1'b0);
    @(posedge clk);
    clock_mode <= 2'h1;
    @(negedge clk);
    chk(pll_cfg.divide_active, 1'b1);
    @(posedge clk);
    clock_mode <= 2'h3;
  endtask
  // Lock loss in bypass and oscillator loss under each enable pair.
  task automatic t_faults;
    for (int e = 0; e < 4; e++) begin
      wr(ADDR_CLOCK_CONTROL, CTRL_RESET | (32'(e) << POS_LOO_RESET));
      pll_locked <= 1'b0;
      clock_mode <= 2'h1;
      @(negedge clk);
      chk(reset_request, e[1]);
      @(posedge clk);
      pll_locked <= 1'b1;
      clock_mode <= 2'h3;
      osc_present <= 1'b0;
      @(negedge clk);
      chk(reset_request, e[0]);
      @(posedge clk);
      osc_present <= 1'b1;
    end
  endtask
  // Tick counts for both sources, gate open and shut.
  task automatic t_timebase;
    int nt;
    int nd;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CLOCK_CONTROL, (CTRL_RESET & ~(32'h3 << POS_DEC_GATE)) | (32'(k) << POS_DEC_GATE));
      nt = 0;
      nd = 0;
      repeat (80) begin
        @(negedge clk);
        nt += timebase_tick;
        nd += decrementer_tick;
      end
      chk(nt >= (k[1] ? 19 : 9) && nt <= (k[1] ? 21 : 11), 1'b1);
      chk(nd, k[0] ? nt : 0);
      @(posedge clk);
    end
    wr(ADDR_CLOCK_CONTROL, CTRL_RESET);
  endtask
  // Enter mode m behind a busy bus cycle, then offer wake event ev.
  task automatic lp(input int m, input int ev, input logic msk, input logic ex);
    int n;
    bus_cycle_busy <= 1'b1;
    wr(ADDR_CLOCK_CONTROL, CTRL_RESET | (32'(m) << POS_LPM_LSB) | (32'(msk) << POS_WAKE_MASK));
    @(negedge clk);
    chk({bus_block, clkout_enable}, 2'b11);
    @(posedge clk);
    bus_cycle_busy <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({clkout_enable, core_clk_enable, osc_pll_enable}, {1'b0, m == 1, m != 3});
    @(posedge clk);
    wake_in <= scclp_wake_t'(4'h8 >> ev);
    hold(n);
    chk(clkout_enable, ex);
    if (m == 3 && ex) chk(n > SU, 1'b1);
    if (!ex) begin
      @(posedge clk);
      wake_in <= scclp_wake_t'(4'h1);
      hold(n);
      chk(clkout_enable, 1'b1);
    end
    chk(bus_block, 1'b0);
    @(posedge clk);
    wake_in <= '0;
    rd(ADDR_CLOCK_CONTROL, CTRL_RESET | (32'(msk) << POS_WAKE_MASK));
  endtask
  // Every mode against every wake source; the pin with mask clear and set.
  task automatic t_lowpower;
    for (int m = 1; m < 4; m++) begin
      for (int ev = 0; ev < 5; ev++) begin
        lp(m, ev % 4, ev == 4, ev >= 3 || (ev != 0 && m != 3));
      end
    end
  endtask
  // Sticky status, mask, level output and clear on read.
  task automatic t_irq;
    @(negedge clk);
    chk(irq, 1'b0);
    @(posedge clk);
    wr(ADDR_IRQ_MASK, 32'h1 << EV_SLEPT);
    @(negedge clk);
    chk(irq, 1'b1);
    @(posedge clk);
    rd(ADDR_IRQ_STATUS, 32'hf);
    rd(ADDR_IRQ_STATUS, 32'h0);
    @(negedge clk);
    chk(irq, 1'b0);
    @(posedge clk);
  endtask
  // Field locks; the first two stay set.
  task automatic t_locks;
    wr(ADDR_FIELD_LOCK, 32'h7 << POS_LOCK_RFD);
    wr(ADDR_CLOCK_CONTROL, CTRL_RESET | MFRFD | LPMB);
    rd(ADDR_CLOCK_CONTROL, CTRL_RESET);
    wr(ADDR_FIELD_LOCK, 32'h0);
    rd(ADDR_FIELD_LOCK, 32'h3 << POS_LOCK_LPM);
    wr(ADDR_CLOCK_CONTROL, CTRL_RESET | MFRFD);
    rd(ADDR_CLOCK_CONTROL, CTRL_RESET | 32'hf);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Reset for five cycles, then run every scenario.
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs;
    t_divide;
    t_faults;
    t_timebase;
    t_lowpower;
    t_irq;
    t_locks;
    give_verdict;
  end
endmodule
